// file: rwt_cfg.svh
`ifndef RWT_CFG_SVH
`define RWT_CFG_SVH

////////////////////////////////////////////////////////////////////////
// register byte offsets
`define RWT_OFS_RELOAD 12'h000
`define RWT_OFS_COUNT 12'h004
`define RWT_OFS_CTRL 12'h008
`define RWT_OFS_ICLR 12'h00c
`define RWT_OFS_RIS 12'h010
`define RWT_OFS_MIS 12'h014
`define RWT_OFS_LOCK 12'hc00

////////////////////////////////////////////////////////////////////////
// control field positions
`define RWT_CTRL_IRQ_COUNT_ENABLE 0
`define RWT_CTRL_RESET_OUT_ENABLE 1

////////////////////////////////////////////////////////////////////////
// reset values and keys
`define RWT_RST_RELOAD 32'hffffffff
`define RWT_RST_COUNT 32'hffffffff
`define RWT_RST_CTRL 2'h0
`define RWT_RST_LOCKED 1'h0
`define RWT_UNLOCK_KEY 32'h1acce551

`endif

// file: rwt_pkg.sv
package rwt_pkg;

    // counter sequencer states, gray along idle -> run -> halt
    typedef enum logic [1:0] {
        RWT_ST_IDLE = 2'h0,
        RWT_ST_RUN = 2'h1,
        RWT_ST_HALT = 2'h3
    } rwt_state_t;

endpackage : rwt_pkg

// file: rwt_down_counter.sv
`timescale 1ns/1ps
`default_nettype none

`include "rwt_cfg.svh"

module rwt_down_counter #(
    parameter int CNT_W = 32
) (
    input wire logic sys_clk_in, // system clock
    input wire logic cnt_rst_in, // sync reset, active high
    input wire logic load_in, // load strobe
    input wire logic [CNT_W-1:0] load_val_in, // value to load
    input wire logic dec_in, // decrement strobe
    output logic [CNT_W-1:0] count_out, // present count
    output logic zero_out // count is zero
);

    ////////////////////////////////////////////////////////////////////
    // width check
    if (CNT_W < 1 || CNT_W > 32) begin : g_cnt_w_check
        $error("rwt_down_counter: CNT_W out of range");
    end

    logic [CNT_W-1:0] count_r;

    ////////////////////////////////////////////////////////////////////
    // load wins over decrement, otherwise hold
    always_ff @(posedge sys_clk_in) begin
        if (cnt_rst_in) begin
            count_r <= CNT_W'(`RWT_RST_COUNT);
        end else if (load_in) begin
            count_r <= load_val_in;
        end else if (dec_in) begin
            count_r <= count_r - CNT_W'(1);
        end
    end

    assign count_out = count_r;
    assign zero_out = (count_r == '0);

endmodule : rwt_down_counter

`default_nettype wire

// file: rwt_lock.sv
`timescale 1ns/1ps
`default_nettype none

`include "rwt_cfg.svh"

module rwt_lock (
    input wire logic sys_clk_in, // system clock
    input wire logic sys_rst_in, // sync reset, active high
    input wire logic lock_wr_in, // write strobe to lock register
    input wire logic [31:0] wdata_in, // written word
    output logic locked_out // writes to other registers blocked
);

    logic locked_r;

    ////////////////////////////////////////////////////////////////////
    // key opens, any other word closes
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            locked_r <= `RWT_RST_LOCKED;
        end else if (lock_wr_in) begin
            locked_r <= (wdata_in != `RWT_UNLOCK_KEY);
        end
    end

    assign locked_out = locked_r;

endmodule : rwt_lock

`default_nettype wire

// file: rwt_top.sv
`timescale 1ns/1ps
`default_nettype none

`include "rwt_cfg.svh"

// Summary of operation
// - after reset the control register is zero, interrupt and reset output off
// - after reset the write lock is open, no register write blocked
// - after reset the counter holds all ones until counting is enabled
// - first enabled count edge after enable loads counter from reload value
// - each later enabled count edge above zero decrements by one, others hold
// - at zero the interrupt rises and the counter reloads for a new run
// - a write to interrupt clear drops the interrupt unless a timeout sets it that cycle and, while running, reloads the counter
// - timeout with interrupt still pending raises reset output if reset enabled
// - after reset output rises the counter stops until the next reset
// - unlock key opens writes, any other word blocks all but lock register
// - lock register reads one when locked, zero when open
// - writing reload value while running reloads the counter at once
// - writing reload value leaves a pending interrupt standing
// - clearing enable freezes the count, setting it again reloads first
// - interrupt rises on an enabled count edge, clear drops it at once
// - load to interrupt takes reload value plus one enabled count edges
// - reload value zero gives an interrupt on the next enabled edge
// - masked status and interrupt pin equal raw status and enable bit
// - control bit one enables reset output, bit zero enables count and irq
module rwt_top
    import rwt_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int CNT_W = 32
) (
    input wire logic sys_clk_in, // system and bus clock
    input wire logic sys_rst_in, // bus reset, sync, active high
    input wire logic count_domain_reset_n_in, // counter reset, active low
    input wire logic count_clock_en_in, // count enable pulse
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb access phase
    input wire logic pwrite_in, // apb write when high
    input wire logic [ADDR_W-1:0] paddr_in, // apb byte address
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic timeout_irq_out, // timeout interrupt
    output logic system_reset_out // system reset request
);

    ////////////////////////////////////////////////////////////////////
    // parameter checks
    if (ADDR_W < 12) begin : g_addr_w_check
        $error("rwt_top: ADDR_W too small for register map");
    end
    if (CNT_W != 32) begin : g_cnt_w_check
        $error("rwt_top: CNT_W must be 32");
    end

    ////////////////////////////////////////////////////////////////////
    // address match on word index
    function automatic logic addr_hit(input logic [11:0] addr, input logic [11:0] ofs);
        addr_hit = (addr[11:2] == ofs[11:2]);
    endfunction : addr_hit

    ////////////////////////////////////////////////////////////////////
    // one status bit placed in bit zero of a read word
    function automatic logic [31:0] flag_word(input logic flag);
        flag_word = {31'h00000000, flag};
    endfunction : flag_word

    logic [11:0] word_addr;
    logic apb_wr;
    logic apb_rd_setup;
    logic locked;
    logic wr_ok;
    logic wr_lock;
    logic wr_reload;
    logic wr_ctrl;
    logic wr_iclr;
    logic cnt_rst;
    logic [31:0] reload_r;
    logic [1:0] ctrl_r;
    logic irq_count_enable;
    logic reset_out_enable;
    logic raw_irq_r;
    logic sys_reset_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    rwt_state_t state_r;
    rwt_state_t state_nxt;
    logic cnt_load;
    logic [CNT_W-1:0] cnt_load_val;
    logic cnt_dec;
    logic [CNT_W-1:0] count;
    logic cnt_zero;
    logic irq_set;
    logic reset_set;
    logic irq_still_pending;
    logic hit_reload;
    logic hit_count;
    logic hit_ctrl;
    logic hit_iclr;
    logic hit_ris;
    logic hit_mis;
    logic hit_lock;

    ////////////////////////////////////////////////////////////////////
    // apb strobes, writes taken in the access phase
    assign word_addr = paddr_in[11:0];
    assign apb_wr = psel_in & penable_in & pwrite_in;
    assign apb_rd_setup = psel_in & ~penable_in & ~pwrite_in;

    // one word match per register, shared by write and read decode
    assign hit_reload = addr_hit(word_addr, `RWT_OFS_RELOAD);
    assign hit_count = addr_hit(word_addr, `RWT_OFS_COUNT);
    assign hit_ctrl = addr_hit(word_addr, `RWT_OFS_CTRL);
    assign hit_iclr = addr_hit(word_addr, `RWT_OFS_ICLR);
    assign hit_ris = addr_hit(word_addr, `RWT_OFS_RIS);
    assign hit_mis = addr_hit(word_addr, `RWT_OFS_MIS);
    assign hit_lock = addr_hit(word_addr, `RWT_OFS_LOCK);

    // lock register stays writable, the rest follow the lock
    // the lock must take writes while closed, else it could never reopen
    assign wr_lock = apb_wr & hit_lock;
    assign wr_ok = apb_wr & ~locked;
    assign wr_reload = wr_ok & hit_reload;
    assign wr_ctrl = wr_ok & hit_ctrl;
    assign wr_iclr = wr_ok & hit_iclr;

    // counter side answers to either reset
    assign cnt_rst = sys_rst_in | ~count_domain_reset_n_in;

    ////////////////////////////////////////////////////////////////////
    // write lock
    rwt_lock u_lock (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .lock_wr_in(wr_lock),
        .wdata_in(pwdata_in),
        .locked_out(locked)
    );

    ////////////////////////////////////////////////////////////////////
    // reload value register
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            reload_r <= `RWT_RST_RELOAD;
        end else if (wr_reload) begin
            reload_r <= pwdata_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ctrl_r <= `RWT_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_r <= pwdata_in[1:0];
        end
    end

    assign irq_count_enable = ctrl_r[`RWT_CTRL_IRQ_COUNT_ENABLE];
    assign reset_out_enable = ctrl_r[`RWT_CTRL_RESET_OUT_ENABLE];

    ////////////////////////////////////////////////////////////////////
    // down counter
    rwt_down_counter #(
        .CNT_W(CNT_W)
    ) u_counter (
        .sys_clk_in(sys_clk_in),
        .cnt_rst_in(cnt_rst),
        .load_in(cnt_load),
        .load_val_in(cnt_load_val),
        .dec_in(cnt_dec),
        .count_out(count),
        .zero_out(cnt_zero)
    );

    // a clear in the same cycle counts as serviced
    assign irq_still_pending = raw_irq_r & ~wr_iclr;

    ////////////////////////////////////////////////////////////////////
    // sequencer: load, count, timeout, stop
    always_comb begin
        state_nxt = state_r;
        cnt_load = 1'b0;
        cnt_load_val = reload_r;
        cnt_dec = 1'b0;
        irq_set = 1'b0;
        reset_set = 1'b0;
        case (state_r)
            RWT_ST_IDLE: begin
                // frozen until enabled, then load on an enabled edge
                if (irq_count_enable && count_clock_en_in) begin
                    cnt_load = 1'b1;
                    state_nxt = RWT_ST_RUN;
                end
            end
            RWT_ST_RUN: begin
                if (!irq_count_enable) begin
                    state_nxt = RWT_ST_IDLE;
                end else begin
                    // bus reloads act at once, without a count edge
                    if (wr_reload) begin
                        cnt_load = 1'b1;
                        cnt_load_val = pwdata_in;
                    end else if (wr_iclr) begin
                        cnt_load = 1'b1;
                    end
                    if (count_clock_en_in) begin
                        if (cnt_zero) begin
                            irq_set = 1'b1;
                            // still pending at zero means the last timeout went unserviced
                            if (irq_still_pending && reset_out_enable) begin
                                reset_set = 1'b1;
                                cnt_load = 1'b0;
                                state_nxt = RWT_ST_HALT;
                            end else if (!cnt_load) begin
                                cnt_load = 1'b1;
                            end
                        end else if (!cnt_load) begin
                            cnt_dec = 1'b1;
                        end
                    end
                end
            end
            RWT_ST_HALT: begin
                // stopped until the next reset
                state_nxt = RWT_ST_HALT;
            end
            default: begin
                state_nxt = RWT_ST_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // sequencer state
    always_ff @(posedge sys_clk_in) begin
        if (cnt_rst) begin
            state_r <= RWT_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // raw interrupt, timeout set wins over a clear
    always_ff @(posedge sys_clk_in) begin
        if (cnt_rst) begin
            raw_irq_r <= 1'b0;
        end else if (irq_set) begin
            raw_irq_r <= 1'b1;
        end else if (wr_iclr) begin
            raw_irq_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // reset request, sticky until reset
    always_ff @(posedge sys_clk_in) begin
        if (cnt_rst) begin
            sys_reset_r <= 1'b0;
        end else if (reset_set) begin
            sys_reset_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux, sampled in the setup phase
    always_comb begin
        prdata_nxt = 32'h00000000;
        if (hit_reload) begin
            prdata_nxt = reload_r;
        end else if (hit_count) begin
            prdata_nxt = count;
        end else if (hit_ctrl) begin
            prdata_nxt = {30'h00000000, ctrl_r};
        end else if (hit_ris) begin
            prdata_nxt = flag_word(raw_irq_r);
        end else if (hit_mis) begin
            prdata_nxt = flag_word(raw_irq_r & irq_count_enable);
        end else if (hit_lock) begin
            prdata_nxt = flag_word(locked);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data register, valid through the access phase
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            prdata_r <= 32'h00000000;
        end else if (apb_rd_setup) begin
            prdata_r <= prdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata_out = prdata_r;
    assign timeout_irq_out = raw_irq_r & irq_count_enable;
    assign system_reset_out = sys_reset_r;

endmodule : rwt_top

`default_nettype wire

// file: rwt_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "rwt_cfg.svh"

module rwt_top_properties #(
    parameter int ADDR_W = 12,
    parameter int CNT_W = 32
) (
    input wire logic sys_clk_in, // clock
    input wire logic sys_rst_in, // bus reset
    input wire logic count_domain_reset_n_in, // count reset
    input wire logic count_clock_en_in, // count enable
    input wire logic psel_in, // select
    input wire logic penable_in, // access
    input wire logic pwrite_in, // write
    input wire logic [ADDR_W-1:0] paddr_in, // address
    input wire logic [31:0] pwdata_in, // write data
    input wire logic [31:0] prdata_out, // read data
    input wire logic timeout_irq_out, // irq
    input wire logic system_reset_out // reset out
);
    logic [11:0] a;
    logic wr;
    logic rd;
    logic locked_r;
    logic [1:0] ctrl_r;
    // accepted write and read setup decode
    assign a = {paddr_in[11:2], 2'h0};
    assign wr = psel_in && penable_in && pwrite_in && (!locked_r || a == `RWT_OFS_LOCK);
    assign rd = psel_in && !penable_in && !pwrite_in;
    default clocking dc @(posedge sys_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // shadow of lock and control
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            locked_r <= `RWT_RST_LOCKED;
            ctrl_r <= `RWT_RST_CTRL;
        end else if (wr && a == `RWT_OFS_LOCK) begin
            locked_r <= pwdata_in != `RWT_UNLOCK_KEY;
        end else if (wr && a == `RWT_OFS_CTRL) begin
            ctrl_r <= pwdata_in[1:0];
        end
    end
    rst_clear_a: assert property ($fell(sys_rst_in)
        |-> !timeout_irq_out && !system_reset_out && prdata_out == 32'h0)
        else $error("outputs not clear after reset");
    irq_mask_a: assert property (timeout_irq_out |-> ctrl_r[0])
        else $error("irq without enable");
    clr_drop_a: assert property (wr && a == `RWT_OFS_ICLR && !count_clock_en_in |=> !timeout_irq_out)
        else $error("irq not dropped by clear");
    rst_hold_a: assert property (system_reset_out && count_domain_reset_n_in |=> system_reset_out)
        else $error("reset out released");
    rst_cause_a: assert property ($rose(system_reset_out) |-> $past(ctrl_r[1]) && $past(timeout_irq_out))
        else $error("reset out without cause");
    lock_read_a: assert property (rd && a == `RWT_OFS_LOCK |=> prdata_out == {31'h0, $past(locked_r)})
        else $error("lock status wrong");
    unmapped_zero_a: assert property (rd && (a == `RWT_OFS_ICLR || (a > `RWT_OFS_MIS && a != `RWT_OFS_LOCK))
        |=> prdata_out == 32'h0)
        else $error("unmapped read not zero");
    mis_read_a: assert property (rd && a == `RWT_OFS_MIS |=> prdata_out == {31'h0, $past(timeout_irq_out)})
        else $error("masked status wrong");
endmodule : rwt_top_properties

bind rwt_top rwt_top_properties #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) u_props (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .count_domain_reset_n_in(count_domain_reset_n_in),
    .count_clock_en_in(count_clock_en_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .timeout_irq_out(timeout_irq_out),
    .system_reset_out(system_reset_out)
);
`default_nettype wire

// file: rwt_apb_host.sv
`timescale 1ns/1ps
`default_nettype none

module rwt_apb_host (
    input wire logic sys_clk_in, // bus clock
    output logic psel_out, // select
    output logic penable_out, // access phase
    output logic pwrite_out, // direction
    output logic [11:0] paddr_out, // byte address
    output logic [31:0] pwdata_out, // write data
    input wire logic [31:0] prdata_in // read data
);
    // idle bus until the first transfer
    initial begin
        psel_out = 1'h0;
        penable_out = 1'h0;
        pwrite_out = 1'h0;
        paddr_out = 12'h000;
        pwdata_out = 32'h00000000;
    end
    // one transfer; released address and data show the inverse of their last value
    task xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge sys_clk_in);
        psel_out <= 1'h1;
        pwrite_out <= w;
        paddr_out <= ad;
        pwdata_out <= wd;
        @(posedge sys_clk_in);
        penable_out <= 1'h1;
        @(posedge sys_clk_in);
        rd = prdata_in;
        psel_out <= 1'h0;
        penable_out <= 1'h0;
        paddr_out <= ~ad;
        pwdata_out <= ~wd;
    endtask : xfer
endmodule : rwt_apb_host
`default_nettype wire

// file: rwt_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rwt_cfg.svh"

module rwt_top_bench;
    typedef struct packed {
        logic [3:0] n;
        logic wr;
        logic [11:0] ad;
        logic [31:0] d;
    } rwt_row_t;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic cnt_rst_n = 1'h1;
    logic en = 1'h0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic irq;
    logic wd_rst;
    logic [31:0] got;
    int n_mismatch = 0;
    int samples_checked = 0;
    // ticks before, write, address, write data or expected read
    rwt_row_t rows [32] = '{
        '{4'h0, 1'h0, 12'h000, 32'hffffffff},
        '{4'h0, 1'h0, 12'h018, 32'h0},
        '{4'h0, 1'h0, 12'hc00, 32'h0},
        '{4'h0, 1'h1, 12'h008, 32'h2},
        '{4'h2, 1'h0, 12'h004, 32'hffffffff},
        '{4'h0, 1'h1, 12'hc00, 32'h0},
        '{4'h0, 1'h0, 12'hc00, 32'h1},
        '{4'h0, 1'h1, 12'h000, 32'h7},
        '{4'h0, 1'h0, 12'h000, 32'hffffffff},
        '{4'h0, 1'h1, 12'hc00, `RWT_UNLOCK_KEY},
        '{4'h0, 1'h0, 12'hc00, 32'h0},
        '{4'h0, 1'h1, 12'h000, 32'h3},
        '{4'h0, 1'h1, 12'h008, 32'h1},
        '{4'h1, 1'h0, 12'h004, 32'h3},
        '{4'h2, 1'h0, 12'h004, 32'h1},
        '{4'h1, 1'h0, 12'h010, 32'h0},
        '{4'h1, 1'h0, 12'h010, 32'h1},
        '{4'h0, 1'h0, 12'h014, 32'h1},
        '{4'h0, 1'h0, 12'h004, 32'h3},
        '{4'h0, 1'h1, 12'h000, 32'h6},
        '{4'h0, 1'h0, 12'h004, 32'h6},
        '{4'h0, 1'h0, 12'h010, 32'h1},
        '{4'h2, 1'h1, 12'h00c, 32'h5a},
        '{4'h0, 1'h0, 12'h004, 32'h6},
        '{4'h0, 1'h0, 12'h014, 32'h0},
        '{4'h0, 1'h1, 12'h008, 32'h0},
        '{4'h2, 1'h0, 12'h004, 32'h6},
        '{4'h0, 1'h1, 12'h000, 32'h4},
        '{4'h0, 1'h1, 12'h008, 32'h1},
        '{4'h1, 1'h0, 12'h004, 32'h4},
        '{4'h0, 1'h1, 12'h000, 32'h0},
        '{4'h1, 1'h0, 12'h010, 32'h1}
    };

    rwt_top #(.ADDR_W(12), .CNT_W(32)) DUT (
        .sys_clk_in(clk), .sys_rst_in(rst), .count_domain_reset_n_in(cnt_rst_n), .count_clock_en_in(en),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .timeout_irq_out(irq), .system_reset_out(wd_rst)
    );
    rwt_apb_host host (
        .sys_clk_in(clk), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr),
        .pwdata_out(pwdata), .prdata_in(prdata)
    );

    // 50 ns clock
    initial begin
        forever #25 clk = ~clk;
    end

    task check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            n_mismatch++;
        end
    endtask : check
    task acc(input logic w, input logic [11:0] ad, input logic [31:0] d);
        host.xfer(w, ad, d, got);
        if (!w) begin
            check($sformatf("read %h", ad), d, got);
        end
    endtask : acc
    // n single enabled count edges
    task tick(input logic [3:0] n);
        repeat (n) begin
            @(posedge clk);
            en <= 1'h1;
            @(posedge clk);
            en <= 1'h0;
        end
    endtask : tick
    task complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    // cut a hang short
    initial begin
        repeat (4000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        foreach (rows[i]) begin
            tick(rows[i].n);
            acc(rows[i].wr, rows[i].ad, rows[i].d);
        end
        // pending irq at zero gives reset out only when enabled
        tick(1);
        acc(1'h0, 12'h014, 32'h1);
        check("irq pin", 32'h1, {31'h0, irq});
        check("reset out", 32'h0, {31'h0, wd_rst});
        acc(1'h1, 12'h008, 32'h3);
        tick(1);
        acc(1'h1, 12'h000, 32'h9);
        tick(2);
        acc(1'h1, 12'h00c, 32'h1);
        acc(1'h0, 12'h004, 32'h0);
        check("irq pin", 32'h0, {31'h0, irq});
        check("reset out", 32'h1, {31'h0, wd_rst});
        // counter-side reset, then full reset
        @(posedge clk);
        cnt_rst_n <= 1'h0;
        @(posedge clk);
        cnt_rst_n <= 1'h1;
        acc(1'h0, 12'h004, 32'hffffffff);
        acc(1'h0, 12'h008, 32'h3);
        check("reset out", 32'h0, {31'h0, wd_rst});
        @(posedge clk);
        rst <= 1'h1;
        @(posedge clk);
        rst <= 1'h0;
        acc(1'h0, 12'h008, 32'h0);
        complete_run();
    end
endmodule : rwt_top_bench
`default_nettype wire
